// file: include/cra_pkg.sv
// constants, types and helpers for the configuration message link
// assumes one tile clock for both ends
package cra_pkg;
    // ------------------------------------------------------------
    // tokens and destination codes
    // ------------------------------------------------------------
    localparam logic [7:0]  TOK_WRITE   = 8'hc0;
    localparam logic [7:0]  TOK_READ    = 8'hc1;
    localparam logic [7:0]  TOK_END     = 8'h01;
    localparam logic [7:0]  TOK_ACK     = 8'h03;
    localparam logic [7:0]  TOK_NACK    = 8'h04;
    localparam logic [15:0] TILE_CODE   = 16'hc20c;
    localparam logic [15:0] NODE_CODE   = 16'hc30c;
    localparam logic [7:0]  PERIPH_CODE = 8'h02;
    localparam logic [7:0]  NOREPLY_LOW = 8'hff;
    localparam logic [7:0]  PS_RES_CODE = 8'h0b;
    localparam int          PS_SHIFT    = 8;
    // ------------------------------------------------------------
    // field sizes and register bank
    // ------------------------------------------------------------
    localparam logic [2:0]  RID_BYTES   = 3'h3;
    localparam logic [2:0]  REG_BYTES   = 3'h2;
    localparam logic [2:0]  WORD_BYTES  = 3'h4;
    localparam logic [2:0]  BYTE_LEN    = 3'h1;
    localparam logic [3:0]  HDR_BYTES   = 4'h5;
    localparam int          BYTE_BIT    = 15;
    localparam int          NREG        = 4;
    localparam int          FIFO_DEPTH  = 32;
    localparam int          FIFO_W      = 33;
    localparam logic [15:0] ID_DEFAULT  = 16'h0001;

    typedef enum logic [1:0] {TGT_TILE, TGT_NODE, TGT_PERIPH, TGT_NONE} cra_tgt_type;

    // resource identifier for a processor-status register
    function automatic logic [31:0] cra_ps_res_id(input logic [23:0] num);
        cra_ps_res_id = (32'(num) << PS_SHIFT) | 32'(PS_RES_CODE);
    endfunction : cra_ps_res_id
endpackage : cra_pkg

// file: include/cra_link_if.sv
// token link between a requesting channel-end and the config block
// assumes both parties share one clock; valid/ready on each direction
`timescale 1ns/1ps
interface cra_link_if;
    logic [31:0] dest;
    logic        req_valid;
    logic        req_ctrl;
    logic [7:0]  req_data;
    logic        req_ready;
    logic        rsp_valid;
    logic        rsp_ctrl;
    logic [7:0]  rsp_data;
    logic [23:0] rsp_dest;
    logic        rsp_ready;

    modport dev (
        input  dest, req_valid, req_ctrl, req_data, rsp_ready,
        output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
    );
    modport req (
        output dest, req_valid, req_ctrl, req_data, rsp_ready,
        input  req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
    );
endinterface : cra_link_if

// file: rtl/cra_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes a single clock and an asynchronous active-low reset
`timescale 1ns/1ps
module cra_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 cnt;
    } cra_fifo_type;

    cra_fifo_type r;
    cra_fifo_type n;
    logic         push;
    logic         pop;

    assign in_ready  = r.cnt != (AW+1)'(DEPTH);
    assign out_valid = r.cnt != '0;
    assign out_data  = r.mem[r.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr] = in_data;
            n.wr        = r.wr + AW'(1);
        end
        if (pop) begin
            n.rd = r.rd + AW'(1);
        end
        n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule : cra_fifo

// file: rtl/cra_device.sv
// configuration-register server: parses token requests, replies
// through a fifo, plus a minimal test-port bypass stage
// assumes requester keeps to message framing; test pins synchronous
`timescale 1ns/1ps
module cra_device
    import cra_pkg::*;
#(
    parameter logic [15:0] TILE_ID = ID_DEFAULT,
    parameter logic [15:0] NODE_ID = ID_DEFAULT
) (
    input  wire logic CLK,
    input  wire logic RSTN,
    cra_link_if.dev   LINK,
    input  wire logic TCK,
    input  wire logic TMS,
    input  wire logic TDI,
    input  wire logic TRST_N,
    output logic      TDO
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        D_IDLE, D_RID, D_REG, D_DATA, D_END, D_EXEC, D_PUSH
    } cra_dstate_type;

    typedef struct packed {
        cra_dstate_type              st;
        cra_tgt_type                 tgt;
        logic [2:0]                  cnt;
        logic                        wr;
        logic [23:0]                 rid;
        logic [15:0]                 rnum;
        logic [31:0]                 wdata;
        logic                        ok;
        logic [31:0]                 rdata;
        logic [2:0]                  dlen;
        logic [2:0]                  pidx;
        logic                        rdy;
        logic [2:0][NREG-1:0][31:0]  regs;
        logic                        ov;
        logic [FIFO_W-1:0]           ow;
        logic                        tck_q;
        logic                        tdi_c;
        logic                        tdo;
    } cra_dev_type;

    cra_dev_type       r;
    cra_dev_type       n;
    logic              rst_n;
    logic              take;
    logic              fin_v;
    logic              fin_rdy;
    logic [FIFO_W-1:0] fin_d;
    logic              fout_v;
    logic              fout_rdy;
    logic [FIFO_W-1:0] fout_d;

    // global test reset clears everything, test stage included
    assign rst_n    = RSTN & TRST_N;
    assign take     = LINK.req_valid && r.rdy;
    assign fout_rdy = !r.ov || LINK.rsp_ready;

    assign LINK.req_ready = r.rdy;
    assign LINK.rsp_valid = r.ov;
    assign LINK.rsp_dest  = r.ow[32:9];
    assign LINK.rsp_ctrl  = r.ow[8];
    assign LINK.rsp_data  = r.ow[7:0];
    assign TDO            = r.tdo;

    function automatic cra_tgt_type tgt_of(input logic [31:0] d);
        if (d[15:0] == TILE_CODE && d[31:16] == TILE_ID) begin
            tgt_of = TGT_TILE;
        end else if (d[15:0] == NODE_CODE && d[31:16] == NODE_ID) begin
            tgt_of = TGT_NODE;
        end else if (d[7:0] == PERIPH_CODE && d[31:16] == NODE_ID) begin
            tgt_of = TGT_PERIPH;
        end else begin
            tgt_of = TGT_NONE;
        end
    endfunction : tgt_of

    // ------------------------------------------------------------
    // request parser, executor and reply builder
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0]  tsel;
        logic [1:0]  idx;
        logic [15:0] hi;
        logic        bytef;
        logic [31:0] rv;
        logic [15:0] nrnum;
        n     = r;
        fin_v = 1'b0;
        fin_d = '0;
        tsel  = (r.tgt == TGT_NONE) ? 2'h0 : r.tgt;
        idx   = r.rnum[1:0];
        bytef = r.dlen == BYTE_LEN;
        hi    = r.rnum;
        if (bytef) begin
            hi[BYTE_BIT] = 1'b0;
        end
        rv    = r.regs[tsel][idx];
        nrnum = {r.rnum[7:0], LINK.req_data};
        case (r.st)
            D_IDLE: begin
                if (take && LINK.req_ctrl &&
                    (LINK.req_data == TOK_WRITE || LINK.req_data == TOK_READ)) begin
                    n.wr  = LINK.req_data == TOK_WRITE;
                    n.tgt = tgt_of(LINK.dest);
                    n.cnt = RID_BYTES;
                    n.st  = D_RID;
                end
            end
            D_RID: begin
                if (take && LINK.req_ctrl) begin
                    n.st = D_IDLE;
                end else if (take) begin
                    n.rid = {r.rid[15:0], LINK.req_data};
                    n.cnt = r.cnt - 3'h1;
                    if (r.cnt == 3'h1) begin
                        n.cnt = REG_BYTES;
                        n.st  = D_REG;
                    end
                end
            end
            D_REG: begin
                if (take && LINK.req_ctrl) begin
                    n.st = D_IDLE;
                end else if (take) begin
                    n.rnum = nrnum;
                    n.cnt  = r.cnt - 3'h1;
                    if (r.cnt == 3'h1) begin
                        // byte form only exists for peripherals
                        n.dlen = (r.tgt == TGT_PERIPH && nrnum[BYTE_BIT])
                                 ? BYTE_LEN : WORD_BYTES;
                        n.cnt  = n.dlen;
                        n.st   = r.wr ? D_DATA : D_END;
                    end
                end
            end
            D_DATA: begin
                if (take && LINK.req_ctrl) begin
                    n.st = D_IDLE;
                end else if (take) begin
                    n.wdata = {r.wdata[23:0], LINK.req_data};
                    n.cnt   = r.cnt - 3'h1;
                    if (r.cnt == 3'h1) begin
                        n.st = D_END;
                    end
                end
            end
            D_END: begin
                if (take) begin
                    // a missing end token drops the message silently
                    n.st = (LINK.req_ctrl && LINK.req_data == TOK_END)
                           ? D_EXEC : D_IDLE;
                end
            end
            D_EXEC: begin
                n.ok = r.tgt != TGT_NONE && hi < NREG && !(r.wr && idx == 2'h0);
                if (n.ok && r.wr) begin
                    if (bytef) begin
                        n.regs[tsel][idx][7:0] = r.wdata[7:0];
                    end else begin
                        n.regs[tsel][idx] = r.wdata;
                    end
                end
                // register 0 of each bank counts requests it has served
                if (r.tgt != TGT_NONE) begin
                    n.regs[tsel][0] = r.regs[tsel][0] + 32'h1;
                end
                n.rdata = bytef ? {rv[7:0], 24'h0} : rv;
                n.dlen  = (n.ok && !r.wr) ? r.dlen : 3'h0;
                n.pidx  = 3'h0;
                n.st    = (r.wr && r.rid[7:0] == NOREPLY_LOW) ? D_IDLE : D_PUSH;
            end
            D_PUSH: begin
                fin_v = 1'b1;
                if (r.pidx == 3'h0) begin
                    fin_d = {r.rid, 1'b1, r.ok ? TOK_ACK : TOK_NACK};
                end else if (r.pidx <= r.dlen) begin
                    fin_d = {r.rid, 1'b0, r.rdata[31:24]};
                end else begin
                    fin_d = {r.rid, 1'b1, TOK_END};
                end
                if (fin_rdy) begin
                    n.pidx = r.pidx + 3'h1;
                    if (r.pidx != 3'h0 && r.pidx <= r.dlen) begin
                        n.rdata = {r.rdata[23:0], 8'h00};
                    end
                    if (r.pidx > r.dlen) begin
                        n.st = D_IDLE;
                    end
                end
            end
            default: begin
                n.st = D_IDLE;
            end
        endcase
        // only handshakes cross the link, so phase never matters
        n.rdy = n.st != D_EXEC && n.st != D_PUSH;
        if (r.ov && LINK.rsp_ready) begin
            n.ov = 1'b0;
        end
        if (fout_v && fout_rdy) begin
            n.ov = 1'b1;
            n.ow = fout_d;
        end
        // test clock is sampled; edges seen one tile cycle late
        n.tck_q = TCK;
        if (TCK && !r.tck_q) begin
            n.tdi_c = TMS ? 1'b0 : TDI;
        end
        if (!TCK && r.tck_q) begin
            n.tdo = r.tdi_c;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // reply buffer: lets replies queue while the link stalls
    // ------------------------------------------------------------
    cra_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) i_cra_fifo (
        .clk       (CLK),
        .rst_n     (rst_n),
        .in_valid  (fin_v),
        .in_ready  (fin_rdy),
        .in_data   (fin_d),
        .out_valid (fout_v),
        .out_ready (fout_rdy),
        .out_data  (fout_d)
    );
endmodule : cra_device

// file: rtl/cra_host.sv
// requesting channel-end: turns one user command into a token
// message and collects the reply
// assumes the device end answers every request except silent writes
`timescale 1ns/1ps
module cra_host
    import cra_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    cra_link_if.req          LINK,
    input  wire logic        CMD_VALID,
    output logic             CMD_READY,
    input  wire logic        CMD_WRITE,
    input  wire logic [1:0]  CMD_TGT,
    input  wire logic [15:0] CMD_ID,
    input  wire logic [7:0]  CMD_PERIPH,
    input  wire logic        CMD_BYTE,
    input  wire logic [23:0] CMD_REPLY,
    input  wire logic [15:0] CMD_REG,
    input  wire logic [31:0] CMD_DATA,
    output logic             DONE_VALID,
    output logic             DONE_OK,
    output logic [31:0]      DONE_DATA
);
    typedef enum logic [2:0] {H_IDLE, H_SEND, H_WAIT, H_DATA, H_TAIL} cra_hstate_type;

    typedef struct packed {
        cra_hstate_type st;
        logic [31:0]    dest;
        logic           wr;
        logic           noreply;
        logic [71:0]    pay;
        logic [3:0]     idx;
        logic [3:0]     plen;
        logic [2:0]     dlen;
        logic [2:0]     cnt;
        logic           v;
        logic           c;
        logic [7:0]     d;
        logic           rr;
        logic           cr;
        logic           ok;
        logic           dv;
        logic           dok;
        logic [31:0]    dd;
    } cra_host_type;

    cra_host_type r;
    cra_host_type n;
    logic         rtake;

    assign rtake          = LINK.rsp_valid && r.rr;
    assign LINK.dest      = r.dest;
    assign LINK.req_valid = r.v;
    assign LINK.req_ctrl  = r.c;
    assign LINK.req_data  = r.d;
    assign LINK.rsp_ready = r.rr;
    assign CMD_READY      = r.cr;
    assign DONE_VALID     = r.dv;
    assign DONE_OK        = r.dok;
    assign DONE_DATA      = r.dd;

    always_comb begin
        logic        bytef;
        logic [15:0] rn;
        cra_tgt_type t;
        n     = r;
        n.dv  = 1'b0;
        t     = cra_tgt_type'(CMD_TGT);
        bytef = t == TGT_PERIPH && CMD_BYTE;
        rn    = CMD_REG;
        rn[BYTE_BIT] = bytef ? 1'b1 : CMD_REG[BYTE_BIT];
        case (r.st)
            H_IDLE: begin
                if (CMD_VALID && r.cr) begin
                    case (t)
                        TGT_TILE:   n.dest = {CMD_ID, TILE_CODE};
                        TGT_NODE:   n.dest = {CMD_ID, NODE_CODE};
                        TGT_PERIPH: n.dest = {CMD_ID, CMD_PERIPH, PERIPH_CODE};
                        default:    n.dest = {CMD_ID, 16'h0000};
                    endcase
                    n.wr   = CMD_WRITE;
                    n.dlen = bytef ? BYTE_LEN : WORD_BYTES;
                    // most significant byte leads every field
                    n.pay  = {CMD_REPLY, rn,
                              bytef ? {CMD_DATA[7:0], 24'h0} : CMD_DATA};
                    n.plen = HDR_BYTES + (CMD_WRITE ? {1'b0, n.dlen} : 4'h0);
                    n.noreply = CMD_WRITE && CMD_REPLY[7:0] == NOREPLY_LOW;
                    n.idx  = 4'h0;
                    n.dd   = 32'h0;
                    n.st   = H_SEND;
                end
            end
            H_SEND: begin
                if (!r.v || LINK.req_ready) begin
                    n.idx = r.idx + 4'h1;
                    if (r.idx == 4'h0) begin
                        n.v = 1'b1;
                        n.c = 1'b1;
                        n.d = r.wr ? TOK_WRITE : TOK_READ;
                    end else if (r.idx <= r.plen) begin
                        n.v   = 1'b1;
                        n.c   = 1'b0;
                        n.d   = r.pay[71:64];
                        n.pay = {r.pay[63:0], 8'h00};
                    end else if (r.idx == r.plen + 4'h1) begin
                        n.v = 1'b1;
                        n.c = 1'b1;
                        n.d = TOK_END;
                    end else begin
                        n.v   = 1'b0;
                        n.idx = r.idx;
                        if (r.noreply) begin
                            n.dv  = 1'b1;
                            n.dok = 1'b1;
                            n.st  = H_IDLE;
                        end else begin
                            n.st = H_WAIT;
                        end
                    end
                end
            end
            H_WAIT: begin
                if (rtake && LINK.rsp_ctrl && LINK.rsp_data == TOK_ACK) begin
                    n.ok  = 1'b1;
                    n.cnt = r.dlen;
                    n.st  = r.wr ? H_TAIL : H_DATA;
                end else if (rtake && LINK.rsp_ctrl && LINK.rsp_data == TOK_NACK) begin
                    n.ok = 1'b0;
                    n.st = H_TAIL;
                end
            end
            H_DATA: begin
                if (rtake) begin
                    n.dd  = {r.dd[23:0], LINK.rsp_data};
                    n.cnt = r.cnt - 3'h1;
                    if (r.cnt == 3'h1) begin
                        n.st = H_TAIL;
                    end
                end
            end
            H_TAIL: begin
                if (rtake && LINK.rsp_ctrl && LINK.rsp_data == TOK_END) begin
                    n.dv  = 1'b1;
                    n.dok = r.ok;
                    n.st  = H_IDLE;
                end
            end
            default: begin
                n.st = H_IDLE;
            end
        endcase
        n.rr = n.st == H_WAIT || n.st == H_DATA || n.st == H_TAIL;
        n.cr = n.st == H_IDLE;
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule : cra_host

// file: dv/cra_link_assertions.sv
// checker for the token link between host and device ends
// assumes one clock and a host that waits for each reply
`timescale 1ns/1ps
module cra_link_assertions
    import cra_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic [31:0] dest,
    input wire logic        req_valid,
    input wire logic        req_ctrl,
    input wire logic [7:0]  req_data,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic        rsp_ctrl,
    input wire logic [7:0]  rsp_data,
    input wire logic [23:0] rsp_dest,
    input wire logic        rsp_ready
);
    // ------------------------------------------------
    // message tracking
    // ------------------------------------------------
    logic [3:0]  idx;
    logic [23:0] rid;
    logic        wr;
    logic        mute;
    wire         take = req_valid && req_ready;
    wire         ends = take && req_ctrl && req_data == TOK_END;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            idx  <= 4'h0;
            rid  <= 24'h0;
            wr   <= 1'b0;
            mute <= 1'b0;
        end else if (take) begin
            idx <= ends ? 4'h0 : idx + 4'h1;
            if (idx == 4'h0) wr <= req_data == TOK_WRITE;
            if (idx != 4'h0 && idx < 4'h4) rid <= {rid[15:0], req_data};
            if (idx == 4'h3) mute <= req_data == NOREPLY_LOW;
        end
    end
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence exec_gap;
        !req_ready ##1 req_ready;
    endsequence
    sequence nack_taken;
        rsp_valid && rsp_ready && rsp_ctrl && rsp_data == TOK_NACK;
    endsequence
    a_req_held: assert property (req_valid && !req_ready |=>
        req_valid && $stable({dest, req_ctrl, req_data})) else $error("request dropped");
    a_rsp_held: assert property (rsp_valid && !rsp_ready |=>
        rsp_valid && $stable({rsp_ctrl, rsp_data, rsp_dest})) else $error("reply dropped");
    a_nack_closes: assert property (nack_taken |=>
        !rsp_valid || (rsp_ctrl && rsp_data == TOK_END)) else $error("failure not closed");
    a_end_blocks: assert property (ends |=> !req_ready)
        else $error("ready after end");
    a_silent_exec: assert property (ends && wr && mute |=> exec_gap)
        else $error("silent write gap");
    a_silent_quiet: assert property (ends && wr && mute |=> (!rsp_valid) [*6])
        else $error("silent write replied");
    a_reply_prompt: assert property (ends && !(wr && mute) |-> ##[3:5] rsp_valid)
        else $error("reply late");
    a_reply_dest: assert property (rsp_valid |-> rsp_dest == rid)
        else $error("reply id wrong");
    a_ready_back: assert property ($fell(req_ready) |-> ##[1:40] req_ready)
        else $error("ready stuck low");
endmodule : cra_link_assertions

// file: dv/config_register_message_access_tb.sv
// bench: host and device ends joined by the link
// assumes device ids left at 1; done results checked from a queue
`timescale 1ns/1ps
module config_register_message_access_tb;
    import cra_pkg::*;
    logic        CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic        cv = 1'b0;
    logic        cw = 1'b0;
    logic [1:0]  ctg = 2'h0;
    logic [15:0] tid = 16'h0001;
    logic        cb = 1'b0;
    logic [23:0] crp = 24'h0;
    logic [15:0] crg = 16'h0;
    logic [31:0] cd = 32'h0;
    logic        tck = 1'b0;
    logic        tms = 1'b0;
    logic        tdi = 1'b0;
    logic        rdy;
    logic        dv;
    logic        dok;
    logic [31:0] dd;
    logic        tdo;
    logic [31:0] seed = 32'h15d50608;
    logic [31:0] mem [4];
    logic [31:0] v;
    logic [98:0] w;
    logic [33:0] e;
    logic [33:0] expq [$];
    logic [8:0]  wq [$];
    int          fails = 0;
    int          checked = 0;
    cra_link_if lk ();
    cra_device i_cra_device (.CLK(CLK), .RSTN(RSTN), .LINK(lk.dev), .TCK(tck),
        .TMS(tms), .TDI(tdi), .TRST_N(RSTN), .TDO(tdo));
    cra_host i_cra_host (.CLK(CLK), .RSTN(RSTN), .LINK(lk.req), .CMD_VALID(cv),
        .CMD_READY(rdy), .CMD_WRITE(cw), .CMD_TGT(ctg), .CMD_ID(tid), .CMD_PERIPH(8'h5a),
        .CMD_BYTE(cb), .CMD_REPLY(crp), .CMD_REG(crg), .CMD_DATA(cd), .DONE_VALID(dv),
        .DONE_OK(dok), .DONE_DATA(dd));
    cra_link_assertions i_cra_link_assertions (.CLK(CLK), .RSTN(RSTN), .dest(lk.dest),
        .req_valid(lk.req_valid), .req_ctrl(lk.req_ctrl), .req_data(lk.req_data),
        .req_ready(lk.req_ready), .rsp_valid(lk.rsp_valid), .rsp_ctrl(lk.rsp_ctrl),
        .rsp_data(lk.rsp_data), .rsp_dest(lk.rsp_dest), .rsp_ready(lk.rsp_ready));
    always #5 CLK = ~CLK;
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checked++;
        if (seen !== ex) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    // ex is {check data, ok, data}; one command outstanding at a time
    task automatic cmd(input logic wt, input logic [1:0] tg, input logic [15:0] rg,
                       input logic [31:0] d, input logic [7:0] lo, input logic b,
                       input logic [33:0] ex);
        expq.push_back(ex);
        @(posedge CLK);
        {cv, cw, ctg, crg, cd, crp, cb} <= {1'b1, wt, tg, rg, d, 16'h0a0b, lo, b};
        do @(negedge CLK); while (rdy !== 1'b1);
        @(posedge CLK);
        cv <= 1'b0;
        while (expq.size() != 0) @(posedge CLK);
    endtask : cmd
    always @(negedge CLK) begin
        if (lk.req_valid === 1'b1 && lk.req_ready === 1'b1) begin
            wq.push_back({lk.req_ctrl, lk.req_data});
        end
        if (dv === 1'b1) begin
            e = expq.size() != 0 ? expq.pop_front() : 34'h0;
            check("done ok", {31'h0, dok}, {31'h0, e[32]});
            if (e[33]) check("done data", dd, e[31:0]);
        end
    end
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        repeat (10) @(posedge CLK);
        RSTN <= 1'b1;
        check("status id", cra_ps_res_id(24'h000012), 32'h0000_120b);
        v = rnd();
        cmd(1'b1, 2'h0, 16'h0001, v, 8'h0c, 1'b0, {2'b11, 32'h0});
        w = {9'h1c0, 9'h00a, 9'h00b, 9'h00c, 9'h000, 9'h001, 1'b0, v[31:24], 1'b0,
             v[23:16], 1'b0, v[15:8], 1'b0, v[7:0], 9'h101};
        check("wire count", wq.size(), 32'd11);
        check("tile dest", lk.dest, 32'h0001_c20c);
        for (int i = 0; i < 11; i++) begin
            check("wire", {23'h0, wq[i]}, {23'h0, w[98 - 9 * i -: 9]});
        end
        $display("test wire done");
        for (int t = 0; t < 2; t++) begin
            for (int r = 1; r < 4; r++) begin
                mem[r] = rnd();
                cmd(1'b1, 2'(t), 16'(r), mem[r], 8'h0c, 1'b0, {2'b11, 32'h0});
            end
            for (int r = 1; r < 4; r++) begin
                cmd(1'b0, 2'(t), 16'(r), 32'h0, 8'h0c, 1'b0, {2'b11, mem[r]});
            end
        end
        check("node dest", lk.dest, 32'h0001_c30c);
        v = rnd();
        cmd(1'b1, 2'h0, 16'h0002, v, 8'hff, 1'b0, {2'b11, 32'h0});
        cmd(1'b0, 2'h0, 16'h0002, 32'h0, 8'h0c, 1'b0, {2'b11, v});
        $display("test tile node done");
        cmd(1'b1, 2'h1, 16'h0000, v, 8'h0c, 1'b0, {2'b10, 32'h0});
        cmd(1'b1, 2'h1, 16'h0004, v, 8'h0c, 1'b0, {2'b10, 32'h0});
        cmd(1'b0, 2'h0, 16'h0004, 32'h0, 8'h0c, 1'b0, {2'b10, 32'h0});
        tid <= 16'h0002;
        cmd(1'b1, 2'h0, 16'h0001, v, 8'h0c, 1'b0, {2'b10, 32'h0});
        tid <= 16'h0001;
        // tile register 0 has served ten requests; the foreign-id one is not counted
        cmd(1'b0, 2'h0, 16'h0000, 32'h0, 8'h0c, 1'b0, {2'b11, 32'h0000_000a});
        $display("test failures done");
        cmd(1'b1, 2'h2, 16'h0001, v, 8'h0c, 1'b0, {2'b11, 32'h0});
        check("periph dest", lk.dest, 32'h0001_5a02);
        cmd(1'b1, 2'h2, 16'h0001, 32'h0000_00a5, 8'h0c, 1'b1, {2'b11, 32'h0});
        cmd(1'b0, 2'h2, 16'h0001, 32'h0, 8'h0c, 1'b1, {2'b11, 32'h0000_00a5});
        cmd(1'b0, 2'h2, 16'h0001, 32'h0, 8'h0c, 1'b0, {2'b11, v[31:8], 8'ha5});
        $display("test peripheral done");
        for (int i = 0; i < 2; i++) begin
            tms <= i[0];
            tdi <= 1'b1;
            @(posedge CLK);
            tck <= 1'b1;
            repeat (2) @(posedge CLK);
            tck <= 1'b0;
            repeat (3) @(posedge CLK);
            check("tdo", {31'h0, tdo}, {31'h0, ~i[0]});
        end
        $display("test port done");
        give_verdict();
    end
    // far above the few hundred cycles the tests need
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule : config_register_message_access_tb
